/* File: cpr_defines.vh */
// Register map constants for the paged CAN register block
`ifndef CPR_DEFINES_VH
`define CPR_DEFINES_VH
`define CPR_OFF_ID_HIGH      8'h60
`define CPR_OFF_ID_LOW       8'h61
`define CPR_OFF_DATA_FIRST   8'h62
`define CPR_OFF_DATA_LAST    8'h69
`define CPR_OFF_MASK0_HIGH   8'h62
`define CPR_OFF_MASK0_LOW    8'h63
`define CPR_OFF_FILT1_HIGH   8'h64
`define CPR_OFF_FILT1_LOW    8'h65
`define CPR_OFF_MASK1_HIGH   8'h66
`define CPR_OFF_MASK1_LOW    8'h67
`define CPR_OFF_TX_ERR       8'h6E
`define CPR_OFF_RX_ERR       8'h6F
`define CPR_OFF_BUF_CSR      8'h6F
`define CPR_OFF_PAGE_SEL     8'h70
`define CPR_OFF_IRQ_STATUS   8'h74
`define CPR_OFF_IRQ_MASK     8'h78
`define CPR_WIN_LOW          8'h60
`define CPR_WIN_HIGH         8'h6F
`define CPR_PAGE_DIAG        3'h0
`define CPR_PAGE_FILTER      3'h4
`define CPR_PAGE_LAST        3'h4
`define CPR_REC_STEP_SMALL   8'h01
`define CPR_REC_STEP_LARGE   8'h08
`define CPR_REC_RELOAD_ABOVE 8'h80
`define CPR_REC_RELOAD_VALUE 8'h78
`define CPR_REC_PASSIVE_ABOVE 8'h7F
`define CPR_REC_MAX          8'hFF
`define CPR_IRQ_BITS         3
`define CPR_IRQ_RX_ERR       0
`define CPR_IRQ_RX_OK        1
`define CPR_IRQ_PASSIVE      2
`define CPR_FILT_HIT0        0
`define CPR_FILT_HIT1        1
`endif

/* File: cpr_paged_regs.v */
// Paged CAN register window with receive error counter and APB access
// How it works
// - Receive error adds one or eight
// - Good reception decrements; above 128 loads 120
// - Count above 127 means error passive
// - Identifier high holds identifier bits ten to three
// - Stored identifier drives arbitration; received identifier drives filtering
// - Five pages share window 60h to 6Fh
// - 60h/61h give identifier high/low per page
// - Payload at 62h-69h; page four masks 0
// - Filter 1 at 64h-67h; rest reserved
// - 6Fh error count or buffer status; 6Eh transmit
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "cpr_defines.vh"
module cpr_paged_regs #(
	parameter NUM_BUFS = 3
)(
	// Clock and reset
	input  wire        mclk_i,
	input  wire        reset_i,
	// APB slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [7:0]  paddr_i,
	input  wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire        pready_o,
	output wire        pslverr_o,
	// Receive engine events
	input  wire        rx_err_i,
	input  wire        rx_err_big_i,
	input  wire        rx_ok_i,
	input  wire [10:0] rx_ident_i,
	input  wire [7:0]  tx_err_count_i,
	// Arbitration and filtering
	input  wire [1:0]  tx_buf_sel_i,
	output reg  [10:0] tx_ident_o,
	output reg  [1:0]  filter_hit_o,
	output reg         error_passive_o,
	// Interrupt
	output wire        irq_o
);
	reg  [7:0]  rec_r;
	reg  [7:0]  rec_nxt;
	reg  [2:0]  page_r;
	reg  [10:0] last_id_r;
	reg  [7:0]  id_hi_r    [0:NUM_BUFS-1];
	reg  [7:0]  id_lo_r    [0:NUM_BUFS-1];
	reg  [7:0]  csr_r      [0:NUM_BUFS-1];
	reg  [7:0]  payload_r  [0:NUM_BUFS*8-1];
	reg  [7:0]  filt_r     [0:7];
	reg  [`CPR_IRQ_BITS-1:0] irq_stat_r;
	reg  [`CPR_IRQ_BITS-1:0] irq_mask_r;
	reg  [31:0] rdata_r;
	reg  [7:0]  rd_byte;
	reg         passive_now;
	reg  [2:0]  page_nxt;
	reg  [10:0] last_id_nxt;
	reg  [31:0] rdata_nxt;
	reg  [10:0] tx_ident_nxt;
	reg  [1:0]  filt_hit_nxt;
	reg  [7:0]  diag_rd;
	reg  [7:0]  filt_rd;
	reg  [7:0]  buf_rd;
	reg  [`CPR_IRQ_BITS-1:0] irq_stat_nxt;
	reg  [`CPR_IRQ_BITS-1:0] irq_mask_nxt;
	wire        diag_page;
	wire        filt_page;
	wire        buf_page;
	wire        wr_window;
	wire        wr_page_sel;
	wire        wr_irq_stat;
	wire        wr_irq_mask;
	wire [4:0]  pay_ix;
	integer     j;
	wire        wr_en;
	wire        rd_en;
	wire [7:0]  wbyte;
	wire        in_window;
	wire [1:0]  buf_ix;
	wire [3:0]  win_off;
	wire [`CPR_IRQ_BITS-1:0] irq_events;
	integer     i;

	// Buffer pages one to three map to buffer index page minus one
	function [1:0] page_to_buf;
		input [2:0] pg;
		begin
			page_to_buf = pg[1:0] - 2'h1;
		end
	endfunction

	// Masked identifier compare shared by both filters
	function filt_match;
		input [10:0] id;
		input [7:0]  fh;
		input [7:0]  fl;
		input [7:0]  mh;
		input [7:0]  ml;
		begin
			filt_match = (((id ^ {fh, fl[7:5]}) & {mh, ml[7:5]}) == 11'h000);
		end
	endfunction

	assign wr_en     = psel_i & penable_i & pwrite_i;
	assign rd_en     = psel_i & ~penable_i & ~pwrite_i;
	assign wbyte     = pwdata_i[7:0];
	assign pready_o  = 1'b1;
	assign pslverr_o = 1'b0;
	assign prdata_o  = rdata_r;
	assign in_window = (paddr_i >= `CPR_WIN_LOW) && (paddr_i <= `CPR_WIN_HIGH);
	assign win_off   = paddr_i[3:0];
	assign buf_ix    = page_to_buf(page_r);

	// Fault confinement counter
	always @*
	begin
		rec_nxt = rec_r;
		if (rx_err_i)
		begin
			if (rx_err_big_i)
				rec_nxt = (rec_r > `CPR_REC_MAX - `CPR_REC_STEP_LARGE) ? `CPR_REC_MAX
					: rec_r + `CPR_REC_STEP_LARGE;
			else if (rec_r != `CPR_REC_MAX)
				rec_nxt = rec_r + `CPR_REC_STEP_SMALL;
		end
		else if (rx_ok_i)
		begin
			if (rec_r > `CPR_REC_RELOAD_ABOVE)
				rec_nxt = `CPR_REC_RELOAD_VALUE;
			else if (rec_r != 8'h00)
				rec_nxt = rec_r - `CPR_REC_STEP_SMALL;
		end
		passive_now = (rec_nxt > `CPR_REC_PASSIVE_ABOVE);
	end

	// Payload slot; eight-way wrap puts 68h and 69h on bytes six and seven
	function [4:0] pay_index;
		input [1:0] b;
		input [3:0] off;
		begin
			pay_index = {b, off[2:0] - 3'h2};
		end
	endfunction

	// Page and write qualifiers
	assign diag_page   = in_window && (page_r == `CPR_PAGE_DIAG);
	assign filt_page   = in_window && (page_r == `CPR_PAGE_FILTER);
	assign buf_page    = in_window && (page_r != `CPR_PAGE_DIAG) && (page_r < `CPR_PAGE_FILTER);
	assign wr_window   = wr_en && in_window;
	assign wr_page_sel = wr_en && (paddr_i == `CPR_OFF_PAGE_SEL);
	assign wr_irq_stat = wr_en && (paddr_i == `CPR_OFF_IRQ_STATUS);
	assign wr_irq_mask = wr_en && (paddr_i == `CPR_OFF_IRQ_MASK);
	assign pay_ix      = pay_index(buf_ix, win_off);

	// Diagnosis page decode
	always @*
	begin
		diag_rd = 8'h00;
		if (paddr_i == `CPR_OFF_ID_HIGH)
			diag_rd = last_id_r[10:3];
		else if (paddr_i == `CPR_OFF_ID_LOW)
			diag_rd = {last_id_r[2:0], 5'h00};
		else if (paddr_i == `CPR_OFF_TX_ERR)
			diag_rd = tx_err_count_i;
		else if (paddr_i == `CPR_OFF_RX_ERR)
			diag_rd = rec_r;
	end

	// Acceptance filter page decode; 68h and up stay reserved
	always @*
	begin
		filt_rd = 8'h00;
		if (paddr_i == `CPR_OFF_ID_HIGH)
			filt_rd = filt_r[0];
		else if (paddr_i == `CPR_OFF_ID_LOW)
			filt_rd = filt_r[1];
		else if (paddr_i == `CPR_OFF_MASK0_HIGH)
			filt_rd = filt_r[2];
		else if (paddr_i == `CPR_OFF_MASK0_LOW)
			filt_rd = filt_r[3];
		else if (paddr_i == `CPR_OFF_FILT1_HIGH)
			filt_rd = filt_r[4];
		else if (paddr_i == `CPR_OFF_FILT1_LOW)
			filt_rd = filt_r[5];
		else if (paddr_i == `CPR_OFF_MASK1_HIGH)
			filt_rd = filt_r[6];
		else if (paddr_i == `CPR_OFF_MASK1_LOW)
			filt_rd = filt_r[7];
	end

	// Message buffer page decode
	always @*
	begin
		buf_rd = 8'h00;
		if (paddr_i == `CPR_OFF_ID_HIGH)
			buf_rd = id_hi_r[buf_ix];
		else if (paddr_i == `CPR_OFF_ID_LOW)
			buf_rd = id_lo_r[buf_ix];
		else if (paddr_i >= `CPR_OFF_DATA_FIRST && paddr_i <= `CPR_OFF_DATA_LAST)
			buf_rd = payload_r[pay_ix];
		else if (paddr_i == `CPR_OFF_BUF_CSR)
			buf_rd = csr_r[buf_ix];
	end

	// Read mux; reserved offsets fall through to zero
	always @*
	begin
		rd_byte = 8'h00;
		if (paddr_i == `CPR_OFF_PAGE_SEL)
			rd_byte = {5'h00, page_r};
		else if (paddr_i == `CPR_OFF_IRQ_STATUS)
			rd_byte = {5'h00, irq_stat_r};
		else if (paddr_i == `CPR_OFF_IRQ_MASK)
			rd_byte = {5'h00, irq_mask_r};
		else if (diag_page)
			rd_byte = diag_rd;
		else if (filt_page)
			rd_byte = filt_rd;
		else if (buf_page)
			rd_byte = buf_rd;
	end

	// Level interrupt from unmasked sticky status
	assign irq_events = {passive_now & ~error_passive_o, rx_ok_i, rx_err_i};
	assign irq_o      = |(irq_stat_r & irq_mask_r);

	// Set beats the write-one clear in the same cycle
	always @*
	begin
		irq_stat_nxt = irq_stat_r | irq_events;
		irq_mask_nxt = irq_mask_r;
		if (wr_irq_stat)
			irq_stat_nxt = (irq_stat_r & ~wbyte[`CPR_IRQ_BITS-1:0]) | irq_events;
		if (wr_irq_mask)
			irq_mask_nxt = wbyte[`CPR_IRQ_BITS-1:0];
	end

	// Unused page codes are dropped so the window always decodes
	always @*
	begin
		page_nxt = page_r;
		if (wr_page_sel && wbyte[2:0] <= `CPR_PAGE_LAST)
			page_nxt = wbyte[2:0];
	end

	// Read data latched at setup so it stands through the access phase
	always @*
	begin
		last_id_nxt = last_id_r;
		rdata_nxt   = rdata_r;
		if (rx_ok_i)
			last_id_nxt = rx_ident_i;
		if (rd_en)
			rdata_nxt = {24'h000000, rd_byte};
	end

	// Buffer code three names no buffer, so it bids with the weakest identifier
	always @*
	begin
		tx_ident_nxt = 11'h7FF;
		if (tx_buf_sel_i < NUM_BUFS)
			tx_ident_nxt = {id_hi_r[tx_buf_sel_i], id_lo_r[tx_buf_sel_i][7:5]};
		filt_hit_nxt[`CPR_FILT_HIT0] = filt_match(rx_ident_i, filt_r[0], filt_r[1],
			filt_r[2], filt_r[3]);
		filt_hit_nxt[`CPR_FILT_HIT1] = filt_match(rx_ident_i, filt_r[4], filt_r[5],
			filt_r[6], filt_r[7]);
	end

	// Control and status registers
	// Error counters have no write path, so software writes fall away
	always @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rec_r           <= 8'h00;
			error_passive_o <= 1'b0;

			page_r          <= `CPR_PAGE_DIAG;
			irq_stat_r      <= {`CPR_IRQ_BITS{1'b0}};
			irq_mask_r      <= {`CPR_IRQ_BITS{1'b0}};
			last_id_r       <= 11'h000;
			rdata_r         <= 32'h00000000;
		end
		else
		begin
			rec_r           <= rec_nxt;
			error_passive_o <= passive_now;

			page_r          <= page_nxt;
			irq_stat_r      <= irq_stat_nxt;
			irq_mask_r      <= irq_mask_nxt;
			last_id_r       <= last_id_nxt;
			rdata_r         <= rdata_nxt;
		end
	end

	// Filter registers; writes at 68h and above fall on reserved space
	always @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			for (j = 0; j < 8; j = j + 1)
				filt_r[j] <= 8'h00;
		end
		else if (wr_window && filt_page)
		begin
			if (paddr_i == `CPR_OFF_ID_HIGH)
				filt_r[0] <= wbyte;
			else if (paddr_i == `CPR_OFF_ID_LOW)
				filt_r[1] <= wbyte;
			else if (paddr_i == `CPR_OFF_MASK0_HIGH)
				filt_r[2] <= wbyte;
			else if (paddr_i == `CPR_OFF_MASK0_LOW)
				filt_r[3] <= wbyte;
			else if (paddr_i == `CPR_OFF_FILT1_HIGH)
				filt_r[4] <= wbyte;
			else if (paddr_i == `CPR_OFF_FILT1_LOW)
				filt_r[5] <= wbyte;
			else if (paddr_i == `CPR_OFF_MASK1_HIGH)
				filt_r[6] <= wbyte;
			else if (paddr_i == `CPR_OFF_MASK1_LOW)
				filt_r[7] <= wbyte;
		end
	end

	// Diagnosis page is read only, so its writes drop here
	always @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			for (i = 0; i < NUM_BUFS; i = i + 1)
			begin
				id_hi_r[i] <= 8'h00;
				id_lo_r[i] <= 8'h00;
				csr_r[i]   <= 8'h00;
			end
			for (i = 0; i < NUM_BUFS*8; i = i + 1)
				payload_r[i] <= 8'h00;
		end
		else if (wr_window && buf_page)
		begin
			if (paddr_i == `CPR_OFF_ID_HIGH)
				id_hi_r[buf_ix] <= wbyte;
			else if (paddr_i == `CPR_OFF_ID_LOW)
				id_lo_r[buf_ix] <= wbyte;
			else if (paddr_i >= `CPR_OFF_DATA_FIRST && paddr_i <= `CPR_OFF_DATA_LAST)
				payload_r[pay_ix] <= wbyte;
			else if (paddr_i == `CPR_OFF_BUF_CSR)
				csr_r[buf_ix] <= wbyte;
		end
	end

	// Identifier feeds arbitration priority and filter key
	always @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			tx_ident_o   <= 11'h000;
			filter_hit_o <= 2'h0;
		end
		else
		begin
			tx_ident_o   <= tx_ident_nxt;
			filter_hit_o <= filt_hit_nxt;
		end
	end
endmodule
`default_nettype wire

/* File: cpr_monitor.sv */
// Checker for the paged CAN register block
`timescale 1ns/10ps
`default_nettype none
module cpr_monitor (
	input wire logic        mclk_i, reset_i, psel_i, penable_i, pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i, prdata_o,
	input wire logic        pready_o, pslverr_o, rx_err_i, rx_ok_i, error_passive_o, irq_o
);
	logic [2:0] mask_r;
	wire        rd_setup = psel_i && !penable_i && !pwrite_i;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// Shadow of the mask register
	always_ff @(posedge mclk_i or posedge reset_i)
		if (reset_i)
			mask_r <= 3'h0;
		else if (psel_i && penable_i && pwrite_i && paddr_i == 8'h78)
			mask_r <= pwdata_i[2:0];
	a_ready_high: assert property (pready_o && !pslverr_o) else $error("ready or error wrong");
	a_upper_zero: assert property (prdata_o[31:8] == 24'h0) else $error("upper read bits set");
	a_reserved_zero: assert property (rd_setup && paddr_i inside {[8'h6A:8'h6D]}
		|=> prdata_o == 32'h0) else $error("reserved read not zero");
	a_read_hold: assert property (!rd_setup |=> $stable(prdata_o)) else $error("read data moved");
	a_passive_rise: assert property ($rose(error_passive_o) |->
		$past(rx_err_i) || $past(rx_err_i, 2)) else $error("passive without error");
	a_passive_fall: assert property ($fell(error_passive_o) |->
		$past(rx_ok_i) || $past(rx_ok_i, 2)) else $error("passive left without reception");
	a_irq_masked: assert property (mask_r == 3'h0 && $past(mask_r) == 3'h0 |-> !irq_o)
		else $error("masked interrupt raised");
	a_err_irq: assert property (rx_err_i && mask_r[0] && !psel_i |-> ##[1:2] irq_o)
		else $error("error interrupt missing");
	cover property (rx_err_i && irq_o);
	cover property ($rose(error_passive_o));
	cover property ($fell(irq_o));
endmodule
bind cpr_paged_regs cpr_monitor u_mon (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_err_i(rx_err_i),
	.rx_ok_i(rx_ok_i), .error_passive_o(error_passive_o), .irq_o(irq_o));
`default_nettype wire

/* File: cpr_node_model.sv */
// Behavioural model of the other CAN nodes feeding receive events
`timescale 1ns/10ps
`default_nettype none
module cpr_node_model (
	input  wire logic        mclk_i,
	output var  logic        rx_err_i, rx_err_big_i, rx_ok_i,
	output var  logic [10:0] rx_ident_i,
	output var  logic [7:0]  tx_err_count_i
);
	initial
	begin
		rx_err_i = 1'b0;
		rx_err_big_i = 1'b0;
		rx_ok_i = 1'b0;
		rx_ident_i = 11'h2A5;
		tx_err_count_i = 8'h5A;
	end
	task automatic send_err(input logic big);
		@(posedge mclk_i);
		rx_err_i <= 1'b1;
		rx_err_big_i <= big;
		@(posedge mclk_i);
		rx_err_i <= 1'b0;
		rx_err_big_i <= ~big;
	endtask
	// Identifier valid only with the pulse, inverted junk after it
	task automatic send_ok(input logic [10:0] id);
		@(posedge mclk_i);
		rx_ok_i <= 1'b1;
		rx_ident_i <= id;
		@(posedge mclk_i);
		rx_ok_i <= 1'b0;
		rx_ident_i <= ~id;
	endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the paged CAN register block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        mclk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o;
	logic        rx_err_i, rx_err_big_i, rx_ok_i, error_passive_o, irq_o;
	logic [7:0]  paddr_i, tx_err_count_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [10:0] rx_ident_i, tx_ident_o, id;
	logic [1:0]  tx_buf_sel_i, filter_hit_o;
	int          n_mismatch = 0;
	int          check_count = 0;
	cpr_paged_regs dut (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(), .rx_err_i(rx_err_i),
		.rx_err_big_i(rx_err_big_i), .rx_ok_i(rx_ok_i), .rx_ident_i(rx_ident_i),
		.tx_err_count_i(tx_err_count_i), .tx_buf_sel_i(tx_buf_sel_i), .tx_ident_o(tx_ident_o),
		.filter_hit_o(filter_hit_o), .error_passive_o(error_passive_o), .irq_o(irq_o));
	cpr_node_model node (.mclk_i(mclk_i), .rx_err_i(rx_err_i), .rx_err_big_i(rx_err_big_i),
		.rx_ok_i(rx_ok_i), .rx_ident_i(rx_ident_i), .tx_err_count_i(tx_err_count_i));
	initial
	begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	function automatic logic [7:0] v(int p, int a);
		return 8'(a * 37 + p * 11);
	endfunction
	function automatic logic [10:0] idf(int p, int a);
		logic [7:0] l;
		l = v(p, a + 1);
		return {v(p, a), l[7:5]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		@(posedge mclk_i);
		while (pready_o !== 1'b1)
			@(posedge mclk_i);
		rd = prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic t_map();
		apb(1, 8'h6F, 32'h55);
		apb(0, 8'h6F, 0);
		chk("rx count", 0, rd);
		apb(0, 8'h6E, 0);
		chk("tx count", 8'h5A, rd);
		for (int p = 1; p <= 4; p++)
		begin
			apb(1, 8'h70, p);
			for (int a = 'h60; a <= 'h6A; a++)
				apb(1, 8'(a), v(p, a));
		end
		for (int p = 0; p <= 4; p++)
		begin
			apb(1, 8'h70, p);
			for (int a = 'h60; a <= 'h6A; a++)
			begin
				apb(0, 8'(a), 0);
				chk("window", (p == 0 || a == 'h6A || (p == 4 && a > 'h67)) ? 0 : v(p, a), rd);
			end
		end
		apb(1, 8'h70, 5);
		apb(0, 8'h60, 0);
		chk("page kept", v(4, 'h60), rd);
		apb(0, 8'h70, 0);
		chk("page sel", 4, rd);
		for (int b = 0; b < 3; b++)
		begin
			tx_buf_sel_i <= 2'(b);
			repeat (2) @(posedge mclk_i);
			@(negedge mclk_i);
			chk("tx ident", idf(b + 1, 'h60), tx_ident_o);
		end
		$display("t_map done");
	endtask
	task automatic t_rec();
		apb(1, 8'h70, 0);
		repeat (16) node.send_err(1);
		node.send_err(0);
		apb(0, 8'h6F, 0);
		chk("rx count up", 129, rd);
		chk("passive", 1, error_passive_o);
		id = idf(4, 'h64);
		node.send_ok(idf(4, 'h60));
		#1 chk("filter0", {((idf(4, 'h60) ^ id) & idf(4, 'h66)) == 0, 1'b1}, filter_hit_o);
		node.send_ok(id);
		#1 chk("filter1", {1'b1, ((id ^ idf(4, 'h60)) & idf(4, 'h62)) == 0}, filter_hit_o);
		apb(0, 8'h6F, 0);
		chk("rx count down", 119, rd);
		chk("active", 0, error_passive_o);
		apb(0, 8'h60, 0);
		chk("last id", v(4, 'h64), rd);
		$display("t_rec done");
	endtask
	task automatic t_irq();
		apb(0, 8'h74, 0);
		chk("status all", 7, rd);
		apb(1, 8'h74, 7);
		apb(1, 8'h78, 1);
		@(negedge mclk_i);
		chk("irq idle", 0, irq_o);
		node.send_err(0);
		@(negedge mclk_i);
		chk("irq set", 1, irq_o);
		apb(0, 8'h74, 0);
		chk("status", 1, rd);
		apb(1, 8'h78, 0);
		@(negedge mclk_i);
		chk("irq masked", 0, irq_o);
		apb(1, 8'h74, 1);
		apb(1, 8'h78, 1);
		@(negedge mclk_i);
		chk("irq cleared", 0, irq_o);
		$display("t_irq done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		{reset_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, tx_buf_sel_i} = {1'b1, 44'h0};
		repeat (10) @(posedge mclk_i);
		reset_i <= 1'b0;
		t_map();
		t_rec();
		t_irq();
		complete_run();
	end
	// Whole run is a few hundred cycles
	initial
	begin
		#2000000;
		n_mismatch++;
		complete_run();
	end
endmodule
`default_nettype wire
